/* File: dv/lps_host_model.sv */
`timescale 1ns/1ps
// host side: one command at a time, waits for the answer before the next
module lps_host_model
	import lps_pkg::*;
(
	input wire logic clk_i, // clock
	input wire logic rsp_valid_i, // response strobe
	input wire logic [1:0] rsp_status_i, // response status
	input wire logic [15:0] rsp_data_i, // response data
	output logic cmd_valid_o, // command strobe
	output logic cmd_write_o, // write when high
	output logic [7:0] cmd_addr_o, // register number
	output logic [15:0] cmd_data_o // write data
);
	initial
	begin
		cmd_valid_o = 1'b0;
		cmd_write_o = 1'b0;
		cmd_addr_o = 8'h00;
		cmd_data_o = 16'h0000;
	end

	task automatic xfer(input logic wr, input logic [7:0] a,
		input logic [15:0] d, output logic [1:0] st, output logic [15:0] q);
		int n;
		n = 0;
		st = 2'h2;
		q = 16'hDEAD;
		@(posedge clk_i);
		#1;
		cmd_valid_o = 1'b1;
		cmd_write_o = wr;
		cmd_addr_o = a;
		cmd_data_o = d;
		@(posedge clk_i);
		#1;
		cmd_valid_o = 1'b0;
		// released bus shows inverted leftovers, never a stale match
		cmd_addr_o = ~a;
		cmd_data_o = ~d;
		while (rsp_valid_i !== 1'b1 && n < 4)
		begin
			@(posedge clk_i);
			#1;
			n++;
		end
		if (rsp_valid_i === 1'b1)
		begin
			st = rsp_status_i;
			q = rsp_data_i;
		end
	endtask
endmodule

/* File: dv/lps_power_ctrl_tb_top.sv */
`timescale 1ns/1ps
module lps_power_ctrl_tb_top;
	import lps_pkg::*;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic needs_unlock_i = 1'b0;
	logic tune_done_i = 1'b0;
	logic tune_fail_i = 1'b0;
	logic power_settled_i = 1'b0;
	logic cmd_valid, cmd_write, rsp_valid, svc_req_n, tune_start;
	logic [7:0] cmd_addr, rsp_addr;
	logic [15:0] cmd_data, rsp_data, channel;
	logic signed [15:0] power;
	logic [1:0] rsp_status, st;
	logic [15:0] q;
	int fails = 0;
	int n_checks = 0;

	always #50 clk_i = ~clk_i;

	lps_power_ctrl lps_power_ctrl_inst (.clk_i(clk_i),
		.sys_rst_i(sys_rst_i), .cmd_valid_i(cmd_valid),
		.cmd_write_i(cmd_write), .cmd_addr_i(cmd_addr),
		.cmd_data_i(cmd_data), .nv_power_i(16'h0123), .nv_load_i(1'b0),
		.power_min_i(16'shFE0C), .power_max_i(16'sh05DC),
		.power_thresh_i(16'h0064), .needs_unlock_i(needs_unlock_i),
		.tune_done_i(tune_done_i), .tune_fail_i(tune_fail_i),
		.power_settled_i(power_settled_i), .rsp_valid_o(rsp_valid),
		.rsp_status_o(rsp_status), .rsp_addr_o(rsp_addr),
		.rsp_data_o(rsp_data), .tune_start_o(tune_start),
		.channel_o(channel), .power_o(power),
		.service_request_line_n_o(svc_req_n));

	lps_host_model lps_host_model_inst (.clk_i(clk_i),
		.rsp_valid_i(rsp_valid), .rsp_status_i(rsp_status),
		.rsp_data_i(rsp_data), .cmd_valid_o(cmd_valid),
		.cmd_write_o(cmd_write), .cmd_addr_o(cmd_addr),
		.cmd_data_o(cmd_data));

	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		n_checks++;
		if (g !== e)
		begin
			fails++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic cmd(input logic wr, input logic [7:0] a,
		input logic [15:0] d);
		lps_host_model_inst.xfer(wr, a, d, st, q);
	endtask

	// one-cycle event pulse, then room for the tracker to settle
	task automatic pulse(ref logic s);
		@(posedge clk_i);
		#1;
		s = 1'b1;
		@(posedge clk_i);
		#1;
		s = 1'b0;
		repeat (2) @(posedge clk_i);
	endtask

	task automatic t_defaults;
		cmd(1'b0, LPS_REG_POWER, 16'h0000);
		chk("power rd st", {14'h0, LPS_ST_OK}, {14'h0, st});
		chk("power default", 16'h0123, q);
		chk("svc req idle", 16'h0001, {15'h0, svc_req_n});
	endtask

	task automatic t_power_ok;
		// set point goes in ahead of any channel write
		cmd(1'b1, LPS_REG_POWER, 16'h03E8);
		chk("power wr st", {14'h0, LPS_ST_OK}, {14'h0, st});
		chk("power echo", 16'h03E8, q);
		chk("power out", 16'h03E8, power);
		cmd(1'b0, LPS_REG_PENDING, 16'h0000);
		chk("power pend", 16'h0001, {15'h0, q[9]});
		cmd(1'b0, LPS_REG_WARN, 16'h0000);
		// host may watch the warning flag during the change
		chk("power warn", 16'h0001, {15'h0, q[LPS_BIT_POWER_WARN]});
		pulse(power_settled_i);
		cmd(1'b0, LPS_REG_PENDING, 16'h0000);
		chk("power unpend", 16'h0000, {15'h0, q[9]});
	endtask

	task automatic t_power_bad;
		cmd(1'b1, LPS_REG_POWER, 16'h0800);
		chk("range st", {14'h0, LPS_ST_EXEC_ERR}, {14'h0, st});
		chk("range data", 16'h0000, q);
		chk("range kept", 16'h03E8, power);
		cmd(1'b0, LPS_REG_PENDING, 16'h0000);
		chk("range err", {12'h0, LPS_ERR_EXEC_FAIL}, {12'h0, q[3:0]});
		needs_unlock_i = 1'b1;
		cmd(1'b1, LPS_REG_POWER, 16'h0400);
		needs_unlock_i = 1'b0;
		chk("unlock st", {14'h0, LPS_ST_EXEC_ERR}, {14'h0, st});
		chk("unlock data", 16'h0000, q);
		chk("unlock kept", 16'h03E8, power);
		cmd(1'b0, LPS_REG_PENDING, 16'h0000);
		chk("unlock err", {12'h0, LPS_ERR_TRAFFIC_REFUSED},
			{12'h0, q[3:0]});
	endtask

	task automatic t_tune;
		cmd(1'b1, LPS_REG_CHANNEL, 16'h0001);
		chk("tune st", {14'h0, LPS_ST_PENDING}, {14'h0, st});
		chk("tune id", 16'h0400, q);
		chk("tune addr", {8'h0, LPS_REG_CHANNEL}, {8'h0, rsp_addr});
		chk("tune start", 16'h0001, {15'h0, tune_start});
		chk("chan out", 16'h0001, channel);
		cmd(1'b0, LPS_REG_PENDING, 16'h0000);
		chk("tune pend", 16'h0001, {15'h0, q[10]});
		pulse(tune_done_i);
		cmd(1'b0, LPS_REG_PENDING, 16'h0000);
		chk("tune ok end", 16'h0000, {15'h0, q[10]});
		chk("svc req ok", 16'h0001, {15'h0, svc_req_n});
		cmd(1'b1, LPS_REG_CHANNEL, 16'h0002);
		pulse(tune_fail_i);
		cmd(1'b0, LPS_REG_PENDING, 16'h0000);
		chk("fail end", 16'h0000, {15'h0, q[10]});
		chk("fail err", {12'h0, LPS_ERR_EXEC_FAIL}, {12'h0, q[3:0]});
		chk("svc req low", 16'h0000, {15'h0, svc_req_n});
		cmd(1'b0, LPS_REG_FATAL, 16'h0000);
		chk("fatal latch", 16'h0001, {15'h0, q[LPS_BIT_EXEC_LATCH]});
		cmd(1'b0, LPS_REG_WARN, 16'h0000);
		chk("warn latch", 16'h0001, {15'h0, q[LPS_BIT_EXEC_LATCH]});
		// writing ones clears the latch; the request line follows it
		cmd(1'b1, LPS_REG_FATAL, 16'h0002);
		cmd(1'b0, LPS_REG_FATAL, 16'h0000);
		chk("fatal clear", 16'h0000, {15'h0, q[LPS_BIT_EXEC_LATCH]});
		chk("svc req clear", 16'h0001, {15'h0, svc_req_n});
	endtask

	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// the whole run is well under a hundred cycles; this bound of 3000 cycles is generous
	initial
	begin
		#(3000 * 100);
		fails++;
		conclude();
	end

	initial
	begin
		repeat (10) @(posedge clk_i);
		#1;
		sys_rst_i = 1'b0;
		repeat (3) @(posedge clk_i);
		t_defaults();
		t_power_ok();
		t_power_bad();
		t_tune();
		conclude();
	end
endmodule

/* File: hdl/lps_op_if.sv */
`timescale 1ns/1ps
interface lps_op_if;
	logic [lps_pkg::LPS_PEND_W-1:0] start;
	logic [lps_pkg::LPS_PEND_W-1:0] done;
	logic [lps_pkg::LPS_PEND_W-1:0] fail;
	logic [lps_pkg::LPS_PEND_W-1:0] busy;
	logic [lps_pkg::LPS_PEND_W-1:0] end_ok;
	logic [lps_pkg::LPS_PEND_W-1:0] end_fail;
	modport tracker (input start, done, fail, output busy, end_ok, end_fail);
	modport ctrl (output start, done, fail, input busy, end_ok, end_fail);
endinterface

/* File: hdl/lps_pend_track.sv */
`timescale 1ns/1ps
module lps_pend_track
	import lps_pkg::*;
(
	input wire logic clk_i, // clock
	input wire logic sys_rst_i, // sync reset
	lps_op_if.tracker op // slot events
);
	logic [LPS_PEND_W-1:0] busy_r, busy_nxt;
	logic [LPS_PEND_W-1:0] ok_r, ok_nxt;
	logic [LPS_PEND_W-1:0] fl_r, fl_nxt;
	genvar g;
	generate
		for (g = 0; g < LPS_PEND_W; g++)
		begin : g_slot
			always_comb
			begin
				busy_nxt[g] = busy_r[g];
				ok_nxt[g] = 1'b0;
				fl_nxt[g] = 1'b0;
				if (busy_r[g] && (op.done[g] || op.fail[g]))
				begin
					busy_nxt[g] = 1'b0;
					ok_nxt[g] = op.done[g] && !op.fail[g];
					fl_nxt[g] = op.fail[g];
				end
				// a start in the ending cycle must not be lost
				if (op.start[g])
					busy_nxt[g] = 1'b1;
			end
		end
	endgenerate
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			busy_r <= '0;
			ok_r <= '0;
			fl_r <= '0;
		end
		else
		begin
			busy_r <= busy_nxt;
			ok_r <= ok_nxt;
			fl_r <= fl_nxt;
		end
	end
	assign op.busy = busy_r;
	assign op.end_ok = ok_r;
	assign op.end_fail = fl_r;
	chk_pend_clears: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(busy_r[LPS_SLOT_TUNE] && op.fail[LPS_SLOT_TUNE])
		|=> fl_r[LPS_SLOT_TUNE]
		&& busy_r[LPS_SLOT_TUNE] == $past(op.start[LPS_SLOT_TUNE]))
		else $error("pending bit not cleared on failure");
endmodule

/* File: hdl/lps_pkg.sv */
package lps_pkg;
	// register numbers
	localparam logic [7:0] LPS_REG_PENDING = 8'h00;
	localparam logic [7:0] LPS_REG_FATAL = 8'h20;
	localparam logic [7:0] LPS_REG_WARN = 8'h21;
	localparam logic [7:0] LPS_REG_SERVICE_MASK = 8'h28;
	localparam logic [7:0] LPS_REG_CHANNEL = 8'h30;
	localparam logic [7:0] LPS_REG_POWER = 8'h31;
	localparam logic [7:0] LPS_REG_MODCFG = 8'h33;
	// response status codes
	localparam logic [1:0] LPS_ST_OK = 2'h0;
	localparam logic [1:0] LPS_ST_EXEC_ERR = 2'h1;
	localparam logic [1:0] LPS_ST_PENDING = 2'h3;
	// error field codes
	localparam logic [3:0] LPS_ERR_OK = 4'h0;
	localparam logic [3:0] LPS_ERR_EXEC_FAIL = 4'h8;
	localparam logic [3:0] LPS_ERR_TRAFFIC_REFUSED = 4'h9;
	// pending slots: tune uses slot 2 (bit 10), power uses slot 1 (bit 9)
	localparam int LPS_PEND_BASE = 8;
	localparam int LPS_PEND_SLOTS = 8;
	localparam int LPS_SLOT_TUNE = 2;
	localparam int LPS_SLOT_POWER = 1;
	// bit positions
	localparam int LPS_BIT_EXEC_LATCH = 1;
	localparam int LPS_BIT_POWER_WARN = 7;
	localparam int LPS_BIT_ALARM_TUNE = 1;
	localparam logic [15:0] LPS_SERVICE_MASK_RST = 16'h0002;
	localparam logic [15:0] LPS_MODCFG_RST = 16'h0002;
	localparam logic [15:0] LPS_ZERO = 16'h0000;
	localparam int LPS_PEND_W = LPS_PEND_SLOTS;
	typedef enum logic [2:0] {
		LPS_IDLE = 3'b001,
		LPS_RESP = 3'b010,
		LPS_LOAD = 3'b100
	} lps_state_t;
endpackage

/* File: hdl/lps_power_ctrl.sv */
`timescale 1ns/1ps
module lps_power_ctrl
	import lps_pkg::*;
(
	input wire logic clk_i, // clock
	input wire logic sys_rst_i, // sync reset, active high
	input wire logic cmd_valid_i, // command packet strobe
	input wire logic cmd_write_i, // 1 write, 0 read
	input wire logic [7:0] cmd_addr_i, // register number
	input wire logic [15:0] cmd_data_i, // write data
	input wire logic [15:0] nv_power_i, // stored power default
	input wire logic nv_load_i, // load stored default pulse
	input wire logic signed [15:0] power_min_i, // lowest allowed power
	input wire logic signed [15:0] power_max_i, // highest allowed power
	input wire logic [15:0] power_thresh_i, // step warning threshold
	input wire logic needs_unlock_i, // power change would unlock
	input wire logic tune_done_i, // tune finished ok
	input wire logic tune_fail_i, // tune failed
	input wire logic power_settled_i, // power reached set point
	output logic rsp_valid_o, // response strobe
	output logic [1:0] rsp_status_o, // response status
	output logic [7:0] rsp_addr_o, // response register
	output logic [15:0] rsp_data_o, // response data
	output logic tune_start_o, // start tuning pulse
	output logic [15:0] channel_o, // channel value
	output logic signed [15:0] power_o, // power set point
	output logic service_request_line_n_o // service request, low active
);
	import lps_pkg::*;
	lps_op_if op();
	lps_pend_track u_track (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.op(op)
	);
	lps_state_t state_r, state_nxt;
	logic [15:0] power_r, power_nxt;
	logic [15:0] chan_r, chan_nxt;
	logic [3:0] err_r, err_nxt;
	logic [15:0] fatal_r, fatal_nxt;
	logic [15:0] warn_r, warn_nxt;
	logic [15:0] svc_mask_r, svc_mask_nxt;
	logic [15:0] cfg_r, cfg_nxt;
	logic rv_r, rv_nxt;
	logic [1:0] rs_r, rs_nxt;
	logic [7:0] ra_r, ra_nxt;
	logic [15:0] rd_r, rd_nxt;
	logic ts_r, ts_nxt;
	logic svc_req_n_r, svc_req_n_nxt;
	logic pw_start;
	logic tu_start;
	logic [15:0] pend_word;
	logic signed [16:0] step;
	logic [16:0] step_abs;
	logic out_rng;

	assign pend_word = {op.busy, 4'h0, err_r};
	assign step = 17'(signed'(cmd_data_i)) - 17'(signed'(power_r));
	assign step_abs = step[16] ? 17'(-step) : 17'(step);
	assign out_rng = (signed'(cmd_data_i) < power_min_i) ||
		(signed'(cmd_data_i) > power_max_i);

	always_comb
	begin
		op.start = '0;
		op.done = '0;
		op.fail = '0;
		op.start[LPS_SLOT_TUNE] = tu_start;
		op.start[LPS_SLOT_POWER] = pw_start;
		op.done[LPS_SLOT_TUNE] = tune_done_i;
		op.fail[LPS_SLOT_TUNE] = tune_fail_i;
		op.done[LPS_SLOT_POWER] = power_settled_i;
	end

	always_comb
	begin
		state_nxt = LPS_IDLE;
		power_nxt = power_r;
		chan_nxt = chan_r;
		err_nxt = err_r;
		fatal_nxt = fatal_r;
		warn_nxt = warn_r;
		svc_mask_nxt = svc_mask_r;
		cfg_nxt = cfg_r;
		rv_nxt = 1'b0;
		rs_nxt = rs_r;
		ra_nxt = ra_r;
		rd_nxt = rd_r;
		ts_nxt = 1'b0;
		svc_req_n_nxt = svc_req_n_r;
		pw_start = 1'b0;
		tu_start = 1'b0;
		case (state_r)
			LPS_LOAD:
			begin
				power_nxt = nv_power_i;
			end
			LPS_IDLE, LPS_RESP:
			begin
				if (nv_load_i)
					power_nxt = nv_power_i;
				if (cmd_valid_i)
				begin
					state_nxt = LPS_RESP;
					rv_nxt = 1'b1;
					ra_nxt = cmd_addr_i;
					rs_nxt = LPS_ST_OK;
					rd_nxt = cmd_data_i;
					if (!cmd_write_i)
					begin
						case (cmd_addr_i)
							LPS_REG_PENDING: rd_nxt = pend_word;
							LPS_REG_FATAL: rd_nxt = fatal_r;
							LPS_REG_WARN: rd_nxt = warn_r;
							LPS_REG_SERVICE_MASK: rd_nxt = svc_mask_r;
							LPS_REG_CHANNEL: rd_nxt = chan_r;
							LPS_REG_POWER: rd_nxt = power_r;
							LPS_REG_MODCFG: rd_nxt = cfg_r;
							default:
							begin
								rs_nxt = LPS_ST_EXEC_ERR;
								rd_nxt = LPS_ZERO;
							end
						endcase
					end
					else
					begin
						case (cmd_addr_i)
							LPS_REG_CHANNEL:
							begin
								chan_nxt = cmd_data_i;
								ts_nxt = 1'b1;
								tu_start = 1'b1;
								rs_nxt = LPS_ST_PENDING;
								rd_nxt = 16'(1 << (LPS_PEND_BASE + LPS_SLOT_TUNE));
							end
							LPS_REG_POWER:
							begin
								if (out_rng)
								begin
									rs_nxt = LPS_ST_EXEC_ERR;
									rd_nxt = LPS_ZERO;
									err_nxt = LPS_ERR_EXEC_FAIL;
								end
								else if (needs_unlock_i)
								begin
									rs_nxt = LPS_ST_EXEC_ERR;
									rd_nxt = LPS_ZERO;
									err_nxt = LPS_ERR_TRAFFIC_REFUSED;
								end
								else
								begin
									power_nxt = cmd_data_i;
									pw_start = 1'b1;
									if (step_abs > {1'b0, power_thresh_i})
										warn_nxt[LPS_BIT_POWER_WARN] = 1'b1;
								end
							end
							LPS_REG_SERVICE_MASK: svc_mask_nxt = cmd_data_i;
							LPS_REG_MODCFG: cfg_nxt = cmd_data_i;
							LPS_REG_FATAL: fatal_nxt = fatal_r & ~cmd_data_i;
							LPS_REG_WARN: warn_nxt = warn_nxt & ~cmd_data_i;
							default:
							begin
								rs_nxt = LPS_ST_EXEC_ERR;
								rd_nxt = LPS_ZERO;
								err_nxt = LPS_ERR_EXEC_FAIL;
							end
						endcase
					end
				end
			end
			default: state_nxt = LPS_IDLE;
		endcase
		// with alarm-during-tune, warning ends at settle
		// a new power write in that cycle keeps its own warning
		if (cfg_r[LPS_BIT_ALARM_TUNE] && op.end_ok[LPS_SLOT_POWER]
			&& !pw_start)
			warn_nxt[LPS_BIT_POWER_WARN] = 1'b0;
		if (op.end_fail[LPS_SLOT_TUNE])
		begin
			err_nxt = LPS_ERR_EXEC_FAIL;
			// latch in fatal and warning; set wins
			fatal_nxt[LPS_BIT_EXEC_LATCH] = 1'b1;
			warn_nxt[LPS_BIT_EXEC_LATCH] = 1'b1;
			if (svc_mask_r[LPS_BIT_EXEC_LATCH])
				svc_req_n_nxt = 1'b0;
		end
		else if (!fatal_r[LPS_BIT_EXEC_LATCH])
			svc_req_n_nxt = 1'b1;
	end

	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			state_r <= LPS_LOAD;
			power_r <= LPS_ZERO;
			chan_r <= LPS_ZERO;
			err_r <= LPS_ERR_OK;
			fatal_r <= LPS_ZERO;
			warn_r <= LPS_ZERO;
			svc_mask_r <= LPS_SERVICE_MASK_RST;
			cfg_r <= LPS_MODCFG_RST;
			rv_r <= 1'b0;
			rs_r <= LPS_ST_OK;
			ra_r <= 8'h00;
			rd_r <= LPS_ZERO;
			ts_r <= 1'b0;
			svc_req_n_r <= 1'b1;
		end
		else
		begin
			state_r <= state_nxt;
			power_r <= power_nxt;
			chan_r <= chan_nxt;
			err_r <= err_nxt;
			fatal_r <= fatal_nxt;
			warn_r <= warn_nxt;
			svc_mask_r <= svc_mask_nxt;
			cfg_r <= cfg_nxt;
			rv_r <= rv_nxt;
			rs_r <= rs_nxt;
			ra_r <= ra_nxt;
			rd_r <= rd_nxt;
			ts_r <= ts_nxt;
			svc_req_n_r <= svc_req_n_nxt;
		end
	end

	assign rsp_valid_o = rv_r;
	assign rsp_status_o = rs_r;
	assign rsp_addr_o = ra_r;
	assign rsp_data_o = rd_r;
	assign tune_start_o = ts_r;
	assign channel_o = chan_r;
	assign power_o = power_r;
	assign service_request_line_n_o = svc_req_n_r;

	chk_tune_pending: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(state_r != LPS_LOAD && cmd_valid_i && cmd_write_i
		&& cmd_addr_i == LPS_REG_CHANNEL)
		|=> rsp_valid_o && rsp_status_o == LPS_ST_PENDING
		&& rsp_data_o == 16'h0400 && op.busy[LPS_SLOT_TUNE])
		else $error("channel write did not pend on slot bit 10");
	chk_svc_req_fail: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(op.end_fail[LPS_SLOT_TUNE] && svc_mask_r[LPS_BIT_EXEC_LATCH])
		|=> !service_request_line_n_o)
		else $error("service request not raised on failure");
	chk_fail_code: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		op.end_fail[LPS_SLOT_TUNE] |=> err_r == LPS_ERR_EXEC_FAIL)
		else $error("failure code not stored");
	chk_range_err: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(state_r != LPS_LOAD && cmd_valid_i && cmd_write_i && !nv_load_i
		&& cmd_addr_i == LPS_REG_POWER && out_rng)
		|=> rsp_status_o == LPS_ST_EXEC_ERR && power_o == $past(power_o))
		else $error("out of range power accepted");
	chk_unlock_ref: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(state_r != LPS_LOAD && cmd_valid_i && cmd_write_i
		&& cmd_addr_i == LPS_REG_POWER && !out_rng && needs_unlock_i)
		|=> rsp_status_o == LPS_ST_EXEC_ERR
		&& err_r == LPS_ERR_TRAFFIC_REFUSED)
		else $error("unlocking power write not refused");
	chk_power_echo: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(state_r != LPS_LOAD && cmd_valid_i && cmd_write_i
		&& cmd_addr_i == LPS_REG_POWER && !out_rng && !needs_unlock_i)
		|=> rsp_status_o == LPS_ST_OK && rsp_data_o == $past(cmd_data_i)
		&& op.busy[LPS_SLOT_POWER])
		else $error("power write not echoed or not pending");
	chk_power_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(state_r != LPS_LOAD && cmd_valid_i && !cmd_write_i
		&& cmd_addr_i == LPS_REG_POWER)
		|=> rsp_status_o == LPS_ST_OK && rsp_data_o == $past(power_r))
		else $error("power read wrong");
	chk_latch_both: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		op.end_fail[LPS_SLOT_TUNE]
		|=> fatal_r[LPS_BIT_EXEC_LATCH] && warn_r[LPS_BIT_EXEC_LATCH])
		else $error("latch missing in fatal or warning");
endmodule
